// ===== hw/lcc_cmd.sv
`timescale 1ns/100ps
// Overview of operation
// - Read-only three-bit type in bits 15:13: 000 slave layout, 001 host layout.
// - Other block kinds use five-bit codes; switch 01000, two ranges reserved.
// - Bits undefined in the selected layout are reserved and read zero.
// - Slave base node tag, writable, warm-cleared, tags requests, matches responses.
// - Read-only unit count of consecutive tags; overflow past 1Fh is undefined.
// - Every write loads master-host bit with the arriving link number.
// - Default direction sends own requests to master host when 0, else opposite.
// - Drop bit, cold-cleared, makes an untrained link reject like end-of-chain.
// - Untrained link without drop or end-of-chain stalls; trained link forwards.
// - A timeout counter keeps a never-training link from hanging the system.
// - Warm select resets to 1; when 0, secondary reset also drops power-good.
// - Double-ended bit is a warm-cleared scratchpad; tied 0 without support.
// - Device number, cold-cleared, is the tag answered for chain-side accesses.
// - Chain-side bit reads 0 from inside the host, 1 from the chain.
// - Hide bit makes chain-side configuration accesses end at end-of-chain.
// - Host-as-node uses device number, drops bridge flag; applied at warm reset.
// - Inbound end-of-chain error sets a write-one-to-clear, cold-cleared bit.
// - Host layout carries the same drop bit as the slave layout.
// - Link ready flag sets only once both receiver and transmitter finish training.
module lcc_cmd #(
    parameter bit HOST_LAYOUT = 1'b0,
    parameter bit SINGLE_LINK = 1'b0,
    parameter bit IMPL_LINK = 1'b0,
    parameter bit DOUBLE_HOSTED = 1'b1,
    parameter bit HAS_WARM_SEL = 1'b1,
    parameter bit HAS_AS_NODE = 1'b1,
    parameter bit CHECK_IEOC = 1'b1,
    parameter bit HAS_TIMEOUT = 1'b1,
    parameter logic [4:0] UNIT_COUNT = 5'h01,
    parameter int TIMEOUT_CYC = lcc_pkg::TIMEOUT_CYC,
    parameter int PG_LEAD_CYC = lcc_pkg::PG_LEAD_CYC
)(
    // Clock and resets
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic WARM_RST_N,
    // Configuration access
    input wire lcc_pkg::lcc_cfg_s CFG_REQ,
    output logic [15:0] CFG_RDATA,
    output logic CFG_RVALID,
    // Link training state
    input wire logic [1:0] LINK_RX_DONE,
    input wire logic [1:0] LINK_TX_DONE,
    input wire logic [1:0] LINK_EOC,
    output logic [1:0] LINK_READY,
    // Packet disposition per transmit link
    input wire logic [1:0] PKT_REQ,
    output logic [1:0] PKT_FWD,
    output logic [1:0] PKT_REJ,
    output logic [1:0] PKT_STALL,
    // Node identity and routing
    input wire logic [4:0] TAG_IN,
    output logic TAG_OURS,
    output logic [4:0] NODE_BASE,
    output logic MASTER_HOST,
    output logic REQ_LINK,
    output logic BRIDGE_FLAG,
    // Chain-side configuration
    input wire logic CHAIN_CFG_REQ,
    output logic CHAIN_CFG_ACK,
    output logic CHAIN_CFG_EOC,
    // Secondary chain reset and errors
    input wire logic SEC_RESET_REQ,
    input wire logic INBOUND_EOC_ERR,
    output logic CHAIN_RST_N,
    output logic POWER_GOOD
);
    logic cmd_wr;
    logic lo_we;
    logic hi_we;
    logic warm_clr;
    logic [4:0] base;
    logic mhost;
    logic ddir;
    logic drop;
    logic warm_sel;
    logic dbl;
    logic [4:0] devn;
    logic hide;
    logic as_node;
    logic as_node_live;
    logic ieoc;
    logic mhost_eff;
    logic hide_eff;
    logic [4:0] next_base;
    logic [4:0] count_eff;
    logic [5:0] tag_top;
    logic [15:0] rd_val;
    logic [1:0] ready;

    assign cmd_wr = CFG_REQ.wr && (CFG_REQ.addr == lcc_pkg::CMD_OFFSET);
    assign lo_we = cmd_wr && CFG_REQ.be[0];
    assign hi_we = cmd_wr && CFG_REQ.be[1];
    // Cold reset is a superset of warm reset
    assign warm_clr = !RST_N || !WARM_RST_N;

    ////////////////////////////////////////////////////////////////////////////
    // Slave layout fields

    always_ff @(posedge CLOCK) begin
        if (warm_clr) begin
            base <= '0;
            mhost <= 1'b0;
            ddir <= 1'b0;
        end else if (!HOST_LAYOUT) begin
            if (lo_we) begin
                base <= CFG_REQ.wdata[lcc_pkg::BASE_LSB +: 5];
            end
            if (hi_we && !SINGLE_LINK) begin
                ddir <= CFG_REQ.wdata[lcc_pkg::DIR_BIT];
            end
            if (cmd_wr) begin
                mhost <= CFG_REQ.link;
            end
        end
    end

    assign mhost_eff = SINGLE_LINK ? IMPL_LINK : mhost;

    ////////////////////////////////////////////////////////////////////////////
    // Shared drop policy

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            drop <= 1'b0;
        end else if (hi_we) begin
            drop <= CFG_REQ.wdata[lcc_pkg::DROP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host layout fields

    always_ff @(posedge CLOCK) begin
        if (warm_clr) begin
            warm_sel <= 1'b1;
            dbl <= 1'b0;
            hide <= 1'b0;
        end else if (HOST_LAYOUT) begin
            if (lo_we && HAS_WARM_SEL) begin
                warm_sel <= CFG_REQ.wdata[lcc_pkg::WARM_BIT];
            end
            if (lo_we && DOUBLE_HOSTED) begin
                dbl <= CFG_REQ.wdata[lcc_pkg::DBL_BIT];
            end
            if (hi_we && DOUBLE_HOSTED) begin
                hide <= CFG_REQ.wdata[lcc_pkg::HIDE_BIT];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            devn <= '0;
            as_node <= 1'b0;
        end else if (HOST_LAYOUT) begin
            if (lo_we) begin
                devn <= CFG_REQ.wdata[lcc_pkg::DEVN_LSB +: 5];
            end
            if (hi_we && HAS_AS_NODE) begin
                as_node <= CFG_REQ.wdata[lcc_pkg::NODE_BIT];
            end
        end
    end

    // Taking effect only at warm reset avoids retagging traffic in flight
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            as_node_live <= 1'b0;
        end else if (!WARM_RST_N) begin
            as_node_live <= as_node;
        end
    end

    // A new error in the clearing cycle survives the clear
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ieoc <= 1'b0;
        end else begin
            ieoc <= (HOST_LAYOUT && CHECK_IEOC && INBOUND_EOC_ERR)
                || (ieoc && !(hi_we && CFG_REQ.wdata[lcc_pkg::IEOC_BIT]));
        end
    end

    assign hide_eff = DOUBLE_HOSTED ? hide : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Readback

    always_comb begin
        rd_val = '0;
        if (HOST_LAYOUT) begin
            rd_val[lcc_pkg::TYPE_LSB +: 3] = lcc_pkg::TYPE_HOST;
            rd_val[lcc_pkg::WARM_BIT] = HAS_WARM_SEL ? warm_sel : 1'b1;
            rd_val[lcc_pkg::DBL_BIT] = dbl;
            rd_val[lcc_pkg::DEVN_LSB +: 5] = devn;
            rd_val[lcc_pkg::SIDE_BIT] = DOUBLE_HOSTED && CFG_REQ.from_chain;
            rd_val[lcc_pkg::HIDE_BIT] = hide_eff;
            rd_val[lcc_pkg::NODE_BIT] = as_node;
            rd_val[lcc_pkg::IEOC_BIT] = ieoc;
        end else begin
            rd_val[lcc_pkg::TYPE_LSB +: 3] = lcc_pkg::TYPE_SLAVE;
            rd_val[lcc_pkg::BASE_LSB +: 5] = base;
            rd_val[lcc_pkg::COUNT_LSB +: 5] = UNIT_COUNT;
            rd_val[lcc_pkg::MHOST_BIT] = mhost_eff;
            rd_val[lcc_pkg::DIR_BIT] = ddir;
        end
        rd_val[lcc_pkg::DROP_BIT] = drop;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CFG_RVALID <= 1'b0;
            CFG_RDATA <= '0;
        end else begin
            CFG_RVALID <= CFG_REQ.rd;
            CFG_RDATA <= (CFG_REQ.rd && CFG_REQ.addr == lcc_pkg::CMD_OFFSET) ? rd_val : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Identity and routing

    assign next_base = HOST_LAYOUT ? (as_node_live ? devn : '0) : base;
    assign count_eff = HOST_LAYOUT ? 5'h01 : UNIT_COUNT;
    // Beyond the top tag the match simply fails; wrap is not modelled
    assign tag_top = {1'b0, next_base} + {1'b0, count_eff} - 6'h01;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            NODE_BASE <= '0;
            TAG_OURS <= 1'b0;
            MASTER_HOST <= 1'b0;
            REQ_LINK <= 1'b0;
            BRIDGE_FLAG <= 1'b0;
            CHAIN_CFG_ACK <= 1'b0;
            CHAIN_CFG_EOC <= 1'b0;
        end else begin
            NODE_BASE <= next_base;
            TAG_OURS <= TAG_IN >= next_base && {1'b0, TAG_IN} <= tag_top;
            MASTER_HOST <= mhost_eff;
            REQ_LINK <= mhost_eff ^ (ddir && !SINGLE_LINK);
            BRIDGE_FLAG <= HOST_LAYOUT && !as_node_live;
            CHAIN_CFG_ACK <= HOST_LAYOUT && CHAIN_CFG_REQ && !hide_eff;
            CHAIN_CFG_EOC <= HOST_LAYOUT && CHAIN_CFG_REQ && hide_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-link training flag and forwarding policy

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_link
            always_ff @(posedge CLOCK) begin
                if (warm_clr) begin
                    ready[gi] <= 1'b0;
                end else if (LINK_RX_DONE[gi] && LINK_TX_DONE[gi]) begin
                    ready[gi] <= 1'b1;
                end
            end

            lcc_fwd #(
                .HAS_TIMEOUT(HAS_TIMEOUT),
                .TIMEOUT_CYC(TIMEOUT_CYC)
            ) u_fwd (
                .clk(CLOCK),
                .rst_n(RST_N),
                .req(PKT_REQ[gi]),
                .eoc(LINK_EOC[gi]),
                .ready(ready[gi]),
                .drop(drop),
                .fwd(PKT_FWD[gi]),
                .rej(PKT_REJ[gi]),
                .stall(PKT_STALL[gi])
            );
        end
    endgenerate

    assign LINK_READY = ready;

    ////////////////////////////////////////////////////////////////////////////
    // Secondary chain reset sequencing

    lcc_rst_seq #(
        .PG_LEAD_CYC(PG_LEAD_CYC)
    ) u_rst (
        .clk(CLOCK),
        .rst_n(RST_N),
        .sbr(HOST_LAYOUT && SEC_RESET_REQ),
        .warm_sel(HAS_WARM_SEL ? warm_sel : 1'b1),
        .chain_rst_n(CHAIN_RST_N),
        .power_good(POWER_GOOD)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    chk_type_field: assert property (
        CFG_RVALID && $past(CFG_REQ.addr) == lcc_pkg::CMD_OFFSET |->
        CFG_RDATA[15:13] == (HOST_LAYOUT ? lcc_pkg::TYPE_HOST : lcc_pkg::TYPE_SLAVE))
        else $error("type field wrong");

    chk_type_code: assert property (
        CFG_RVALID |-> CFG_RDATA[15:11] < lcc_pkg::TYPE5_SWITCH)
        else $error("type field uses another block code");

    chk_rsvd_zero: assert property (
        CFG_RVALID |-> (HOST_LAYOUT ? CFG_RDATA[9] == 1'b0 : 1'b1))
        else $error("reserved bit not zero");

    chk_master_load: assert property (
        !HOST_LAYOUT && !SINGLE_LINK && cmd_wr && WARM_RST_N |=>
        mhost == $past(CFG_REQ.link))
        else $error("master host not loaded");

    chk_warm_base: assert property (
        !WARM_RST_N |=> base == 5'h00 ##1 NODE_BASE == next_base)
        else $error("base not cleared by warm reset");

    chk_drop_reject: assert property (
        drop && PKT_REQ[1] && !ready[1] && $stable(drop) |=> PKT_REJ[1] && !PKT_STALL[1])
        else $error("untrained link not rejected");

    chk_fwd_ready: assert property (
        PKT_REQ[0] && ready[0] && !LINK_EOC[0] |=> PKT_FWD[0] && !PKT_REJ[0])
        else $error("trained link not forwarding");

    chk_ieoc_set: assert property (
        HOST_LAYOUT && CHECK_IEOC && INBOUND_EOC_ERR |=> ieoc)
        else $error("inbound error lost");

    chk_hide_eoc: assert property (
        HOST_LAYOUT && CHAIN_CFG_REQ && hide_eff |=> CHAIN_CFG_EOC && !CHAIN_CFG_ACK)
        else $error("hidden host answered chain");

    chk_ready_both: assert property (
        $rose(ready[0]) |-> $past(LINK_RX_DONE[0] && LINK_TX_DONE[0]))
        else $error("ready set without both sides");

    chk_pg_order: assert property (
        $fell(POWER_GOOD) |-> !CHAIN_RST_N && !$past(CHAIN_RST_N))
        else $error("power-good dropped before reset");

    cov_write: cover property (cmd_wr ##1 CFG_REQ.rd);
    cov_stall_fwd: cover property (PKT_STALL[0] ##[1:20] PKT_FWD[0]);
    cov_cold_seq: cover property ($fell(POWER_GOOD) ##[1:300] $rose(CHAIN_RST_N));
endmodule

// ===== hw/lcc_fwd.sv
`timescale 1ns/100ps
module lcc_fwd #(
    parameter bit HAS_TIMEOUT = 1'b1,
    parameter int TIMEOUT_CYC = lcc_pkg::TIMEOUT_CYC
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link state
    input wire logic req,
    input wire logic eoc,
    input wire logic ready,
    input wire logic drop,
    // Disposition
    output logic fwd,
    output logic rej,
    output logic stall
);
    logic [15:0] wait_cnt;
    logic next_stall;
    logic expired;
    logic waiting;

    // A link that never trains would otherwise hang the packet forever
    assign expired = HAS_TIMEOUT && (wait_cnt >= 16'(TIMEOUT_CYC));
    assign waiting = req && !eoc && !ready && !drop;
    assign next_stall = waiting && !expired;

    // Count holds once expired, so the packet keeps being rejected
    always_ff @(posedge clk) begin
        if (!rst_n || !waiting) begin
            wait_cnt <= '0;
        end else if (!expired) begin
            wait_cnt <= wait_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fwd <= 1'b0;
            rej <= 1'b0;
            stall <= 1'b0;
        end else begin
            fwd <= req && !eoc && ready;
            rej <= req && (eoc || (!ready && (drop || expired)));
            stall <= next_stall;
        end
    end
endmodule

// ===== hw/lcc_pkg.sv
package lcc_pkg;
    // Register placement and layout selector
    localparam logic [7:0] CMD_OFFSET = 8'h02;
    localparam int TYPE_LSB = 13;
    localparam logic [2:0] TYPE_SLAVE = 3'h0;
    localparam logic [2:0] TYPE_HOST = 3'h1;
    // Five-bit codes used by other block kinds
    localparam logic [4:0] TYPE5_SWITCH = 5'h08;
    localparam logic [4:0] TYPE5_RSV_A_LO = 5'h09;
    localparam logic [4:0] TYPE5_RSV_A_HI = 5'h0F;
    localparam logic [4:0] TYPE5_RSV_B_LO = 5'h1D;
    localparam logic [4:0] TYPE5_RSV_B_HI = 5'h1F;
    // Shared field
    localparam int DROP_BIT = 12;
    // Slave layout fields
    localparam int BASE_LSB = 0;
    localparam int COUNT_LSB = 5;
    localparam int MHOST_BIT = 10;
    localparam int DIR_BIT = 11;
    localparam logic [4:0] MAX_TAG = 5'h1F;
    // Host layout fields
    localparam int WARM_BIT = 0;
    localparam int DBL_BIT = 1;
    localparam int DEVN_LSB = 2;
    localparam int SIDE_BIT = 7;
    localparam int HIDE_BIT = 8;
    localparam int NODE_BIT = 10;
    localparam int IEOC_BIT = 11;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STALL_TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = (STALL_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int PG_LEAD_NS = 1000;
    localparam int PG_LEAD_CYC = (PG_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic link;
        logic from_chain;
    } lcc_cfg_s;

    typedef enum logic [1:0] {RS_IDLE, RS_RST_LO, RS_PG_LO, RS_PG_UP} lcc_rst_e;
endpackage

// ===== hw/lcc_rst_seq.sv
`timescale 1ns/100ps
module lcc_rst_seq #(
    parameter int PG_LEAD_CYC = lcc_pkg::PG_LEAD_CYC
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic sbr,
    input wire logic warm_sel,
    // Chain reset pins
    output logic chain_rst_n,
    output logic power_good
);
    lcc_pkg::lcc_rst_e state;
    logic [7:0] cnt;
    logic cold_seq;
    logic lead_done;

    assign lead_done = cnt >= 8'(PG_LEAD_CYC);

    // Reset goes low before power-good drops and rises after it returns
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= lcc_pkg::RS_IDLE;
            cnt <= '0;
            cold_seq <= 1'b0;
            chain_rst_n <= 1'b1;
            power_good <= 1'b1;
        end else begin
            cnt <= lead_done ? cnt : cnt + 8'h01;
            unique case (state)
                lcc_pkg::RS_IDLE: begin
                    if (sbr) begin
                        cold_seq <= !warm_sel;
                        chain_rst_n <= 1'b0;
                        cnt <= '0;
                        state <= lcc_pkg::RS_RST_LO;
                    end
                end
                lcc_pkg::RS_RST_LO: begin
                    if (cold_seq && lead_done) begin
                        power_good <= 1'b0;
                        state <= lcc_pkg::RS_PG_LO;
                    end else if (!cold_seq && !sbr) begin
                        chain_rst_n <= 1'b1;
                        state <= lcc_pkg::RS_IDLE;
                    end
                end
                lcc_pkg::RS_PG_LO: begin
                    if (!sbr) begin
                        power_good <= 1'b1;
                        cnt <= '0;
                        state <= lcc_pkg::RS_PG_UP;
                    end
                end
                lcc_pkg::RS_PG_UP: begin
                    if (lead_done) begin
                        chain_rst_n <= 1'b1;
                        state <= lcc_pkg::RS_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ===== verif/lcc_link_peer.sv
`timescale 1ns/100ps
// Far-side link partner: receiver training ends before transmitter training
module lcc_link_peer (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic [1:0] train_go,
    input wire logic [1:0] end_chain,
    // Link state toward the block
    output logic [1:0] rx_done,
    output logic [1:0] tx_done,
    output logic [1:0] eoc
);
    logic [2:0] cnt [2];
    ////////////////////////////////////////////////////////////////////////
    // A partial training leaves rx done alone, so a premature ready shows
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!train_go[i]) begin
                cnt[i] <= 3'h0;
                rx_done[i] <= 1'b0;
                tx_done[i] <= 1'b0;
            end else begin
                if (cnt[i] != 3'h7) begin
                    cnt[i] <= cnt[i] + 3'h1;
                end
                rx_done[i] <= (cnt[i] >= 3'h1);
                tx_done[i] <= (cnt[i] >= 3'h3);
            end
        end
    end
    assign eoc = end_chain;
endmodule

// ===== verif/link_capability_command_register_tb.sv
`timescale 1ns/100ps
module link_capability_command_register_tb;
    localparam logic [4:0] UNITS = 5'h03;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic warm_rst_n = 1'b1;
    lcc_pkg::lcc_cfg_s cfg = '0;
    logic [15:0] rdata;
    logic rvalid, tag_ours, master_host, req_link, bridge_flag;
    logic [1:0] rx_done, tx_done, eoc, ready, fwd, rej, stall;
    logic [1:0] pkt_req = 2'h0;
    logic [1:0] train_go = 2'h0;
    logic [1:0] end_chain = 2'h0;
    logic [4:0] tag_in = 5'h00;
    logic [4:0] node_base, base;
    lcc_pkg::lcc_cfg_s h_cfg = '0;
    logic [15:0] h_rdata;
    logic h_rvalid, h_ack, h_eoc, h_bridge, h_crst_n, h_pg;
    logic [4:0] h_base;
    logic chain_req = 1'b0;
    logic sec_req = 1'b0;
    logic ieoc_err = 1'b0;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    lcc_cmd #(.UNIT_COUNT(UNITS), .TIMEOUT_CYC(8), .PG_LEAD_CYC(2)) dut (
        .CLOCK(clock), .RST_N(rst_n), .WARM_RST_N(warm_rst_n),
        .CFG_REQ(cfg), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
        .LINK_RX_DONE(rx_done), .LINK_TX_DONE(tx_done), .LINK_EOC(eoc),
        .LINK_READY(ready), .PKT_REQ(pkt_req), .PKT_FWD(fwd), .PKT_REJ(rej),
        .PKT_STALL(stall), .TAG_IN(tag_in), .TAG_OURS(tag_ours),
        .NODE_BASE(node_base), .MASTER_HOST(master_host), .REQ_LINK(req_link),
        .BRIDGE_FLAG(bridge_flag), .CHAIN_CFG_REQ(1'b0), .CHAIN_CFG_ACK(),
        .CHAIN_CFG_EOC(), .SEC_RESET_REQ(1'b0), .INBOUND_EOC_ERR(1'b0),
        .CHAIN_RST_N(), .POWER_GOOD()
    );
    lcc_cmd #(.HOST_LAYOUT(1'b1), .TIMEOUT_CYC(8), .PG_LEAD_CYC(2)) dut_h (
        .CLOCK(clock), .RST_N(rst_n), .WARM_RST_N(warm_rst_n),
        .CFG_REQ(h_cfg), .CFG_RDATA(h_rdata), .CFG_RVALID(h_rvalid),
        .LINK_RX_DONE(rx_done), .LINK_TX_DONE(tx_done), .LINK_EOC(eoc),
        .LINK_READY(), .PKT_REQ(2'h0), .PKT_FWD(), .PKT_REJ(),
        .PKT_STALL(), .TAG_IN(tag_in), .TAG_OURS(),
        .NODE_BASE(h_base), .MASTER_HOST(), .REQ_LINK(),
        .BRIDGE_FLAG(h_bridge), .CHAIN_CFG_REQ(chain_req), .CHAIN_CFG_ACK(h_ack),
        .CHAIN_CFG_EOC(h_eoc), .SEC_RESET_REQ(sec_req), .INBOUND_EOC_ERR(ieoc_err),
        .CHAIN_RST_N(h_crst_n), .POWER_GOOD(h_pg)
    );
    lcc_link_peer peer (
        .clk(clock), .train_go(train_go), .end_chain(end_chain),
        .rx_done(rx_done), .tx_done(tx_done), .eoc(eoc)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_port(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_read(input logic [15:0] exp, input logic [15:0] got);
        cmp_port("register read", exp, got);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [15:0] exp_reg(logic drop, logic dir, logic mh, logic [4:0] b);
        return {3'h0, drop, dir, mh, UNITS, b};
    endfunction
    // Strobe drops one cycle later, so a following access starts on a fresh edge
    task automatic access(input logic wr, input logic [15:0] d, input logic [1:0] be,
                          input logic link);
        @(negedge clock);
        cfg = '{wr: wr, rd: !wr, addr: lcc_pkg::CMD_OFFSET, wdata: d, be: be, link: link,
                from_chain: 1'b0};
        @(negedge clock);
        cfg.wr = 1'b0;
        cfg.rd = 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] exp);
        exp_q.push_back(exp);
        access(1'b0, 16'h0000, 2'h0, 1'b0);
    endtask
    task automatic h_access(input logic wr, input logic [15:0] d, input logic chain);
        @(negedge clock);
        h_cfg = '{wr: wr, rd: !wr, addr: lcc_pkg::CMD_OFFSET, wdata: d, be: 2'h3, link: 1'b0,
                  from_chain: chain};
        @(negedge clock);
        h_cfg.wr = 1'b0;
        h_cfg.rd = 1'b0;
    endtask
    task automatic h_rd(input logic [15:0] exp, input logic chain);
        exp_q.push_back(exp);
        h_access(1'b0, 16'h0000, chain);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read data is a one-cycle pulse, so it is looked at once per cycle
    always @(negedge clock) begin
        if (rvalid === 1'b1 || h_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_port("unexpected read", 16'h0000, 16'hFFFF);
            end else begin
                cmp_read(exp_q.pop_front(), rvalid === 1'b1 ? rdata : h_rdata);
            end
        end
    end
    initial begin
        #(50 * 2000);
        miscompares++;
        $display("[ERR] watchdog expected finish seen hang");
        give_verdict();
    end
    initial begin
        base = 5'($urandom(2145) % 30);
        settle(5);
        rst_n = 1'b1;
        rd_reg(exp_reg(1'b0, 1'b0, 1'b0, 5'h00));
        access(1'b1, 16'hFFE0 | 16'(base), 2'h3, 1'b1);
        rd_reg(exp_reg(1'b1, 1'b1, 1'b1, base));
        cmp_port("req link", 16'h0, 16'(req_link));
        cmp_port("node base", 16'(base), 16'(node_base));
        cmp_port("bridge flag", 16'h0, 16'(bridge_flag));
        for (int off = 0; off < 4; off++) begin
            tag_in = base + 5'(off);
            settle(2);
            cmp_port("tag match", 16'(off < 3), 16'(tag_ours));
        end
        access(1'b1, 16'h0000, 2'h0, 1'b0);
        rd_reg(exp_reg(1'b1, 1'b1, 1'b0, base));
        cmp_port("req link", 16'h1, 16'(req_link));
        access(1'b1, 16'h0000, 2'h3, 1'b1);
        settle(1);
        cmp_port("req link", 16'h1, 16'(req_link));
        cmp_port("master host", 16'h1, 16'(master_host));
        pkt_req = 2'h1;
        settle(2);
        cmp_port("stall", 16'h1, 16'(stall));
        cmp_port("forward", 16'h0, 16'(fwd));
        settle(10);
        cmp_port("reject", 16'h1, 16'(rej));
        pkt_req = 2'h0;
        train_go = 2'h1;
        settle(3);
        cmp_port("ready", 16'h0, 16'(ready));
        for (int i = 0; i < 20 && ready[0] !== 1'b1; i++) begin
            settle(1);
        end
        cmp_port("ready", 16'h1, 16'(ready));
        pkt_req = 2'h1;
        settle(2);
        cmp_port("forward", 16'h1, 16'(fwd));
        end_chain = 2'h1;
        settle(2);
        cmp_port("reject", 16'h1, 16'(rej));
        end_chain = 2'h0;
        pkt_req = 2'h2;
        access(1'b1, 16'h1800 | 16'(base), 2'h3, 1'b1);
        settle(1);
        cmp_port("reject", 16'h2, 16'(rej));
        // Warm reset retrains the link, so the partner restarts training as well
        train_go = 2'h0;
        warm_rst_n = 1'b0;
        settle(1);
        warm_rst_n = 1'b1;
        rd_reg(exp_reg(1'b1, 1'b0, 1'b0, 5'h00));
        cmp_port("ready", 16'h0, 16'(ready));
        rst_n = 1'b0;
        settle(2);
        rst_n = 1'b1;
        rd_reg(exp_reg(1'b0, 1'b0, 1'b0, 5'h00));
        h_rd(16'h2001, 1'b0);
        h_access(1'b1, 16'hF782 | 16'({base, 2'h0}), 1'b0);
        h_rd({3'h1, 5'h15, 1'b1, base, 2'h2}, 1'b1);
        chain_req = 1'b1;
        settle(1);
        chain_req = 1'b0;
        cmp_port("chain eoc ack", 16'h2, {14'h0, h_eoc, h_ack});
        h_access(1'b1, 16'hF682 | 16'({base, 2'h0}), 1'b0);
        chain_req = 1'b1;
        settle(1);
        chain_req = 1'b0;
        cmp_port("chain eoc ack", 16'h1, {14'h0, h_eoc, h_ack});
        ieoc_err = 1'b1;
        settle(1);
        ieoc_err = 1'b0;
        h_rd({3'h1, 5'h1C, 1'b0, base, 2'h2}, 1'b0);
        h_access(1'b1, 16'hFE82 | 16'({base, 2'h0}), 1'b0);
        h_rd({3'h1, 5'h14, 1'b0, base, 2'h2}, 1'b0);
        // Warm select was last written before the chain reset request rises
        sec_req = 1'b1;
        settle(1);
        cmp_port("chain reset pins", 16'h1, {14'h0, h_crst_n, h_pg});
        settle(3);
        cmp_port("chain reset pins", 16'h0, {14'h0, h_crst_n, h_pg});
        sec_req = 1'b0;
        settle(1);
        cmp_port("chain reset pins", 16'h1, {14'h0, h_crst_n, h_pg});
        settle(3);
        cmp_port("chain reset pins", 16'h3, {14'h0, h_crst_n, h_pg});
        cmp_port("bridge flag", 16'h1, 16'(h_bridge));
        cmp_port("node base", 16'h0, 16'(h_base));
        warm_rst_n = 1'b0;
        settle(1);
        warm_rst_n = 1'b1;
        settle(1);
        cmp_port("node base", 16'(base), 16'(h_base));
        cmp_port("bridge flag", 16'h0, 16'(h_bridge));
        h_rd({3'h1, 5'h14, 1'b0, base, 2'h1}, 1'b0);
        settle(2);
        cmp_port("pending reads", 16'h0, 16'(exp_q.size()));
        give_verdict();
    end
endmodule
